// File: verilog/texel_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module texel_decoder
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire texel_decode_pkg::decode_req_s req_in,
    output logic rsp_valid_out,
    output texel_decode_pkg::decode_rsp_s rsp_out
);
    import texel_decode_pkg::*;

    logic [WORD_W-1:0] packed_block_word;
    logic s1_valid_q;
    logic [WORD_W-1:0] s1_word_q;
    logic [3:0] s1_pixel_q;
    decode_mode_e s1_mode_q;
    logic s1_wide_q;

    logic [7:0] base_value;
    logic [3:0] multiplier;
    logic [3:0] table_idx;
    logic [2:0] selectors [PIXELS];
    logic [2:0] pixel_sel;
    logic signed [4:0] modifier;
    logic signed [9:0] product;
    logic signed [13:0] base_term;
    logic signed [13:0] mod_term;
    logic signed [13:0] sum_d;

    logic s2_valid_q;
    logic signed [13:0] s2_sum_q;
    decode_mode_e s2_mode_q;
    logic s2_wide_q;

    logic [10:0] value11;
    logic [7:0] truncated8;
    logic [7:0] value8;
    logic [15:0] value16;
    decode_rsp_s rsp_d;
    logic rsp_valid_q;
    decode_rsp_s rsp_q;

    always_comb
    begin
        packed_block_word = '0;
        for (int i = 0; i < BLOCK_BYTES; i++)
        begin
            packed_block_word[WORD_W-1-BYTE_W*i -: BYTE_W] = req_in.block_bytes[i];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            s1_valid_q <= 1'b0;
        end
        else
        begin
            s1_valid_q <= req_valid_in;
        end
    end

    // Capture request fields
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            s1_word_q <= '0;
            s1_pixel_q <= 4'h0;
            s1_mode_q <= eleven_bit_unsigned_mode;
            s1_wide_q <= 1'b0;
        end
        else if (req_valid_in)
        begin
            s1_word_q <= packed_block_word;
            s1_pixel_q <= req_in.pixel;
            s1_mode_q <= req_in.mode;
            s1_wide_q <= req_in.wide;
        end
    end

    assign base_value = s1_word_q[BASE_MSB:BASE_LSB];
    assign multiplier = s1_word_q[MULT_MSB:MULT_LSB];
    assign table_idx = s1_word_q[TIDX_MSB:TIDX_LSB];

    generate
        for (genvar k = 0; k < PIXELS; k++)
        begin : g_sel
            assign selectors[k] = s1_word_q[SEL_TOP-SEL_W*k -: SEL_W];
        end
    endgenerate

    assign pixel_sel = selectors[s1_pixel_q];

    modifier_rom u_modifier_rom
    (
        .table_idx_in(table_idx),
        .selector_in(pixel_sel),
        .modifier_out(modifier)
    );

    assign product = modifier * $signed({1'b0, multiplier});

    assign base_term = $signed({3'h0, base_value, BASE_FILL});

    always_comb
    begin
        mod_term = '0;
        if (multiplier != 4'h0)
        begin
            mod_term = $signed(14'(product)) <<< SCALE_SHIFT;
        end
        else if (s1_mode_q == eleven_bit_unsigned_mode)
        begin
            mod_term = $signed(14'(modifier));
        end
        else
        begin
            mod_term = '0;
        end
    end

    assign sum_d = base_term + mod_term;

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            s2_valid_q <= 1'b0;
        end
        else
        begin
            s2_valid_q <= s1_valid_q;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            s2_sum_q <= '0;
            s2_mode_q <= eleven_bit_unsigned_mode;
            s2_wide_q <= 1'b0;
        end
        else if (s1_valid_q)
        begin
            s2_sum_q <= sum_d;
            s2_mode_q <= s1_mode_q;
            s2_wide_q <= s1_wide_q;
        end
    end

    always_comb
    begin
        if (s2_sum_q < 14'sh0000)
        begin
            value11 = 11'h000;
        end
        else if (s2_sum_q > MAX11)
        begin
            value11 = MAX11[10:0];
        end
        else
        begin
            value11 = s2_sum_q[10:0];
        end
    end

    assign truncated8 = value11[10:ALPHA_DROP];

    assign value8 = (truncated8 > MAX8) ? MAX8 : truncated8;

    assign value16 = 16'({5'h00, value11} << WIDE_LSHIFT) + 16'(value11 >> WIDE_RSHIFT);

    always_comb
    begin
        rsp_d.value11 = value11;
        rsp_d.value8 = value8;
        rsp_d.mode = s2_mode_q;
        if (s2_mode_q == eight_bit_alpha_mode)
        begin
            rsp_d.value = {8'h00, value8};
        end
        else if (s2_wide_q)
        begin
            rsp_d.value = value16;
        end
        else
        begin
            rsp_d.value = {5'h00, value11};
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            rsp_valid_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= s2_valid_q;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            rsp_q <= '0;
        end
        else if (s2_valid_q)
        begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp_valid_out = rsp_valid_q;
    assign rsp_out = rsp_q;

endmodule : texel_decoder
`default_nettype wire

// File: include/texel_decode_pkg.sv
package texel_decode_pkg;

    localparam int unsigned BYTE_W = 8;
    localparam int unsigned BLOCK_BYTES = 8;
    localparam int unsigned WORD_W = 64;
    localparam int unsigned PIXELS = 16;

    localparam int unsigned BASE_MSB = 63;
    localparam int unsigned BASE_LSB = 56;
    localparam int unsigned MULT_MSB = 55;
    localparam int unsigned MULT_LSB = 52;
    localparam int unsigned TIDX_MSB = 51;
    localparam int unsigned TIDX_LSB = 48;
    localparam int unsigned SEL_TOP = 47;
    localparam int unsigned SEL_W = 3;

    localparam logic [2:0] BASE_FILL = 3'h4;
    localparam int unsigned SCALE_SHIFT = 3;
    localparam int unsigned ALPHA_DROP = 3;
    localparam logic signed [13:0] MAX11 = 14'sh7ff;
    localparam logic [7:0] MAX8 = 8'hff;
    localparam int unsigned WIDE_LSHIFT = 5;
    localparam int unsigned WIDE_RSHIFT = 6;
    localparam int unsigned LATENCY = 3;

    localparam logic signed [4:0] MOD_TABLE [16][8] = '{
        '{-5'sd3, -5'sd6, -5'sd9, -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14},
        '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12},
        '{-5'sd2, -5'sd5, -5'sd8, -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12},
        '{-5'sd2, -5'sd4, -5'sd6, -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12},
        '{-5'sd3, -5'sd6, -5'sd8, -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11},
        '{-5'sd3, -5'sd7, -5'sd9, -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10},
        '{-5'sd4, -5'sd7, -5'sd8, -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10},
        '{-5'sd3, -5'sd5, -5'sd8, -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10},
        '{-5'sd2, -5'sd6, -5'sd8, -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd5, -5'sd8, -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd4, -5'sd8, -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd5, -5'sd7, -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9},
        '{-5'sd3, -5'sd4, -5'sd7, -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9},
        '{-5'sd1, -5'sd2, -5'sd3, -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9},
        '{-5'sd4, -5'sd6, -5'sd8, -5'sd9, 5'sd3, 5'sd5, 5'sd7, 5'sd8},
        '{-5'sd3, -5'sd5, -5'sd7, -5'sd9, 5'sd2, 5'sd4, 5'sd6, 5'sd8}
    };

    typedef enum logic [0:0] {
        eleven_bit_unsigned_mode = 1'b0,
        eight_bit_alpha_mode = 1'b1
    } decode_mode_e;

    typedef struct packed {
        logic [0:7][7:0] block_bytes;
        logic [3:0] pixel;
        decode_mode_e mode;
        logic wide;
    } decode_req_s;

    typedef struct packed {
        logic [15:0] value;
        logic [10:0] value11;
        logic [7:0] value8;
        decode_mode_e mode;
    } decode_rsp_s;

endpackage : texel_decode_pkg

// File: verilog/modifier_rom.sv
`timescale 1ns/10ps
`default_nettype none
module modifier_rom
(
    input wire logic [3:0] table_idx_in,
    input wire logic [2:0] selector_in,
    output logic signed [4:0] modifier_out
);
    import texel_decode_pkg::*;

    assign modifier_out = MOD_TABLE[table_idx_in][selector_in];

endmodule : modifier_rom
`default_nettype wire

// File: sim/texel_decoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
module texel_decoder_checker
    import texel_decode_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire texel_decode_pkg::decode_req_s req_in,
    input wire logic rsp_valid_out,
    input wire texel_decode_pkg::decode_rsp_s rsp_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_lat; req_valid_in |-> ##3 rsp_valid_out; endproperty
    a_lat: assert property (p_lat) else $error("no result");
    property p_quiet; $fell(sys_rst_in) |-> !rsp_valid_out [*3]; endproperty
    a_quiet: assert property (p_quiet) else $error("early strobe");
    property p_trunc; rsp_valid_out |-> rsp_out.value8 == rsp_out.value11[10:3]; endproperty
    a_trunc: assert property (p_trunc) else $error("bad value8");
    property p_alpha; rsp_valid_out && rsp_out.mode |-> rsp_out.value == {8'h00, rsp_out.value8};
    endproperty
    a_alpha: assert property (p_alpha) else $error("bad alpha");
    property p_wide; rsp_valid_out && !rsp_out.mode && $past(req_in.wide, 3)
        |-> rsp_out.value == {rsp_out.value11, 5'h00} + rsp_out.value11[10:6]; endproperty
    a_wide: assert property (p_wide) else $error("bad wide");
    property p_narrow; rsp_valid_out && !rsp_out.mode && !$past(req_in.wide, 3)
        |-> rsp_out.value == {5'h00, rsp_out.value11}; endproperty
    a_narrow: assert property (p_narrow) else $error("bad narrow");
    property p_mode; rsp_valid_out |-> rsp_out.mode == $past(req_in.mode, 3); endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    property p_zero; rsp_valid_out && rsp_out.mode && $past(req_in.block_bytes[1][7:4], 3) == 4'h0
        |-> rsp_out.value8 == $past(req_in.block_bytes[0], 3); endproperty
    a_zero: assert property (p_zero) else $error("bad zero mult");
    property p_only; rsp_valid_out |-> $past(req_valid_in, 3); endproperty
    a_only: assert property (p_only) else $error("stray result");
    property p_hold; !rsp_valid_out && !$past(sys_rst_in) |-> $stable(rsp_out); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    c_alpha: cover property (rsp_valid_out && rsp_out.mode);
    c_wide: cover property (rsp_valid_out && !rsp_out.mode && rsp_out.value[15:11] != 5'h00);
    c_b2b: cover property (rsp_valid_out [*2]);
endmodule : texel_decoder_checker
bind texel_decoder texel_decoder_checker u_chk (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out));
`default_nettype wire

// File: sim/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_model
    import texel_decode_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic go_in,
    input wire logic [63:0] word_in,
    input wire logic [5:0] ctl_in,
    output logic req_valid_out,
    output texel_decode_pkg::decode_req_s req_out
);
    always_ff @(posedge core_clk_in)
    begin
        req_valid_out <= go_in;
        req_out <= go_in ? {word_in, ctl_in} : ~req_out;
    end
endmodule : fetch_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import texel_decode_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic go = 1'b0;
    logic [63:0] word = '0;
    logic [5:0] ctl = '0;
    logic [31:0] seed = 32'hc1dab8fd;
    logic [63:0] corners [4] = '{64'h672d0c0000000000, 64'h670d0c0000000000,
        64'hfff01c0000000000, 64'h00f000c000000000};
    logic req_valid;
    decode_req_s req;
    logic rsp_valid_out;
    decode_rsp_s rsp_out;
    int mismatches = 0;
    int total_checks = 0;
    logic [27:0] exp_q [$];
    always #20 core_clk_in = ~core_clk_in;
    fetch_model u_fetch (.core_clk_in(core_clk_in), .go_in(go), .word_in(word), .ctl_in(ctl),
        .req_valid_out(req_valid), .req_out(req));
    texel_decoder dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .req_valid_in(req_valid), .req_in(req), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [27:0] expect_rsp(input logic [63:0] w, input logic [5:0] c);
        int md;
        int s;
        md = MOD_TABLE[w[51:48]][w[47 - 3 * c[5:2] -: 3]];
        s = int'(w[63:56]) * 8 + 4 + (w[55:52] != 0 ? md * int'(w[55:52]) * 8 : (c[1] ? 0 : md));
        s = s < 0 ? 0 : (s > 2047 ? 2047 : s);
        return {c[1], c[1] ? 16'(s >> 3) : (c[0] ? 16'((s << 5) + (s >> 6)) : 16'(s)), 11'(s)};
    endfunction : expect_rsp
    task automatic check(input string name, input logic [27:0] seen, input logic [27:0] want);
        total_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic send(input logic [63:0] w, input logic [5:0] c);
        @(posedge core_clk_in);
        go <= 1'b1;
        word <= w;
        ctl <= c;
        exp_q.push_back(expect_rsp(w, c));
    endtask : send
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    always @(negedge core_clk_in)
    begin
        if (rsp_valid_out === 1'b1 && exp_q.size() == 0)
            check("spurious", 28'h1, 28'h0);
        else if (rsp_valid_out === 1'b1)
            check("rsp", {rsp_out.mode, rsp_out.value, rsp_out.value11}, exp_q.pop_front());
    end
    initial
    begin
        #(40 * 3000);
        mismatches++;
        complete_run();
    end
    initial
    begin
        check("ex_narrow", expect_rsp(corners[0], 6'h04), {1'b0, 16'h029c, 11'h29c});
        check("ex_wide", expect_rsp(corners[0], 6'h05), {1'b0, 16'h538a, 11'h29c});
        check("ex_alpha", expect_rsp(corners[0], 6'h06), {1'b1, 16'h0053, 11'h29c});
        check("ex_zero", expect_rsp(corners[1], 6'h04), {1'b0, 16'h0332, 11'h332});
        check("ex_azero", expect_rsp(corners[1], 6'h06), {1'b1, 16'h0067, 11'h33c});
        repeat (16) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        foreach (corners[i])
            for (int k = 0; k < 4; k++)
                send(corners[i], {4'h1, 2'(k)});
        send(corners[0], 6'h04);
        @(posedge core_clk_in);
        go <= 1'b0;
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        check("rst_out", {rsp_out.mode, rsp_out.value, rsp_out.value11}, 28'h0);
        sys_rst_in <= 1'b0;
        exp_q.delete();
        repeat (400)
        begin
            send({seed, lfsr(seed)}, seed[5:0]);
            seed = lfsr(lfsr(seed));
        end
        @(posedge core_clk_in);
        go <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        check("left", 28'(exp_q.size()), 28'h0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
